// ### psda_bridge.sv
// Program space data access bridge: table reads and writes and the
// program window that maps upper data space onto a program page.
// Assumes the core and the flash array run on clk_sys; the core holds
// a request until coreReady, the flash answers each request with a
// one-cycle flashAck.
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`include "psda_params.svh"

// Overview of operation
// R1: Low-word table read, word mode, returns program bits 15:0 as data.
// R2: Low-word byte read returns upper byte if select is 1, else lower byte.
// R3: Upper-byte word read returns bits 23:16 low, upper data byte zero.
// R4: Upper-byte byte read gives bits 23:16 at select 0, zero at select 1.
// R5: Table address is table page concatenated with the 16-bit effective address.
// R6: Table page bit 7 selects user memory at 0, configuration at 1.
// R7: Configuration space allows only reads of implemented areas; writes refused.
// R8: Two address steps per program word; low-word and upper-byte spaces side by side.
// R9: Redirect to program space only when address bit 15 and window enable set.
// R10: Visibility page gives upper bits of 16K-word page; address 14:0 lower bits.
// R11: Window covers data addresses 8000h and up, the upper 32 Kbytes.
// R12: Window read returns only the low 16 bits of the program word.
// R13: Window data read takes an extra cycle for two program fetches.
// R14: Outside repeat, moves cost one extra cycle, others two.
// R15: In repeat, edge iterations cost two extra cycles, others none.
// R16: Window access waits while a table read or write is in progress.
// R17: Firmware fills upper byte of window data with all ones or zeros.
// R18: Self-programming writes rows of 64 words and erases blocks of 512.
// R19: Window address bit 23 zero, bit 15 from visibility page bit 0.
// R20: Every formed program address has its least significant bit zero.
// R21: Byte select for byte-mode table reads is effective address bit 0.
module psda_bridge
    import psda_pkg::*;
#(
    parameter logic [23:0] CFG_IMPL_FIRST = 24'h800000,
    parameter logic [23:0] CFG_IMPL_LAST = 24'h8007FE
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic coreReq,
    input wire logic [2:0] coreOp,
    input wire logic coreByteMode,
    input wire logic [15:0] coreEa,
    input wire logic [15:0] coreWrData,
    input wire logic coreIsMove,
    input wire logic coreInRepeat,
    input wire logic coreRepeatEdge,
    output logic coreReady,
    output logic coreDone,
    output logic [15:0] coreRdData,
    output logic coreRefused,
    output logic coreRedirected,
    output logic [1:0] coreExtra,
    output logic flashReq,
    output logic flashWe,
    output logic [2:0] flashMask,
    output logic [23:0] flashAddr,
    output logic [23:0] flashWrData,
    input wire logic flashAck,
    input wire logic [23:0] flashRdData
);

    psda_regs_t r;
    psda_regs_t next_r;

    // =================================================================
    // Address formation
    // =================================================================

    logic [23:0] tableAddr;
    logic [23:0] windowAddr;
    logic windowHit;
    logic cfgSpace;
    logic cfgImplemented;
    logic [1:0] penalty;
    logic busReq;
    logic [31:0] busMux;

    // Table page on top of the word index, window page on top of EA 14:1.
    assign tableAddr = {r.tablePage, coreEa[15:1], 1'b0}; // [R5] [R8] [R20]
    assign windowAddr = {1'b0, r.visPage, coreEa[14:1], 1'b0}; // [R10] [R19] [R20]
    assign windowHit = coreEa[`PSDA_EA_WINDOW_BIT] & r.windowEnable; // [R9] [R11]
    assign cfgSpace = r.tablePage[`PSDA_CFG_SPACE_BIT]; // [R6]
    assign cfgImplemented = (tableAddr >= CFG_IMPL_FIRST) && (tableAddr <= CFG_IMPL_LAST);

    // Extra instruction cycles charged to a window access.
    always_comb begin
        if (coreInRepeat) begin
            penalty = coreRepeatEdge ? `PSDA_PEN_REP_EDGE : `PSDA_PEN_REP_MID; // [R15]
        end else begin
            penalty = coreIsMove ? `PSDA_PEN_MOVE : `PSDA_PEN_OTHER; // [R14]
        end
    end

    // =================================================================
    // Register read multiplexer
    // =================================================================

    assign busReq = avs_read | avs_write;

    // Unmapped offsets read as zero.
    always_comb begin
        busMux = 32'h00000000;
        case (avs_address)
            `PSDA_REG_TABLE_PAGE: busMux[7:0] = r.tablePage;
            `PSDA_REG_VIS_PAGE: busMux[7:0] = r.visPage;
            `PSDA_REG_CORE_CTRL: busMux[`PSDA_WIN_EN_BIT] = r.windowEnable;
            `PSDA_REG_STATUS: begin
                busMux[`PSDA_ST_BUSY_BIT] = (r.state != ST_IDLE);
                busMux[`PSDA_ST_REFUSED_BIT] = r.lastRefused;
                busMux[`PSDA_ST_SUSPEND_BIT] = r.state[1] | r.state[2];
            end
            `PSDA_REG_ROW_STAT: begin
                busMux[`PSDA_RS_COUNT_LSB +: 7] = r.rowCount;
                busMux[`PSDA_RS_BLOCK_LSB +: 14] = r.eraseBlock;
            end
            default: busMux = 32'h00000000;
        endcase
    end

    // =================================================================
    // Next state
    // =================================================================

    // Fills the next copy of the whole state from the current one.
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.busAck = busReq & ~r.busAck;
        if (busReq & ~r.busAck) begin
            next_r.busRdData = busMux;
        end
        if (avs_write & r.busAck & avs_byteenable[0]) begin
            case (avs_address)
                `PSDA_REG_TABLE_PAGE: next_r.tablePage = avs_writedata[7:0];
                `PSDA_REG_VIS_PAGE: next_r.visPage = avs_writedata[7:0];
                `PSDA_REG_CORE_CTRL: next_r.windowEnable = avs_writedata[`PSDA_WIN_EN_BIT];
                default: next_r.tablePage = r.tablePage;
            endcase
        end
        case (r.state)
            ST_IDLE: begin
                if (coreReq) begin
                    next_r.op = psda_op_t'(coreOp);
                    next_r.byteMode = coreByteMode;
                    next_r.byteSel = coreEa[`PSDA_EA_BYTE_BIT]; // [R21]
                    next_r.refused = 1'b0;
                    next_r.redirected = 1'b0;
                    next_r.extra = 2'h0;
                    next_r.rdData = 16'h0000;
                    next_r.flashWe = 1'b0;
                    case (psda_op_t'(coreOp))
                        OP_DATA_READ: begin
                            if (windowHit) begin
                                next_r.redirected = 1'b1;
                                next_r.extra = penalty;
                                next_r.flashAddr = windowAddr;
                                next_r.flashReq = 1'b1;
                                next_r.state = ST_WIN_FETCH1;
                            end else begin
                                next_r.done = 1'b1;
                            end
                        end
                        OP_DATA_WRITE: begin
                            // The window is read-only, so a write into it is refused.
                            next_r.refused = windowHit;
                            next_r.lastRefused = windowHit;
                            next_r.done = 1'b1;
                        end
                        OP_TABLE_READ_LOW, OP_TABLE_READ_UPPER: begin
                            if (cfgSpace & ~cfgImplemented) begin
                                next_r.refused = 1'b1; // [R7]
                                next_r.lastRefused = 1'b1;
                                next_r.done = 1'b1;
                            end else begin
                                next_r.flashAddr = tableAddr;
                                next_r.flashReq = 1'b1;
                                next_r.state = ST_TABLE_FETCH;
                            end
                        end
                        OP_TABLE_WRITE_LOW, OP_TABLE_WRITE_UPPER: begin
                            next_r.flashAddr = tableAddr;
                            next_r.flashWe = 1'b1;
                            if (psda_op_t'(coreOp) == OP_TABLE_WRITE_LOW) begin
                                next_r.flashWrData = {8'h00, coreWrData};
                                if (!coreByteMode) begin
                                    next_r.flashMask = `PSDA_MASK_LOW_WORD;
                                end else if (coreEa[`PSDA_EA_BYTE_BIT]) begin
                                    next_r.flashMask = `PSDA_MASK_BYTE1;
                                    next_r.flashWrData = {8'h00, coreWrData[7:0], 8'h00};
                                end else begin
                                    next_r.flashMask = `PSDA_MASK_BYTE0;
                                end
                            end else begin
                                next_r.flashMask = `PSDA_MASK_HIGH;
                                next_r.flashWrData = {coreWrData[7:0], 16'h0000};
                            end
                            if (cfgSpace) begin
                                next_r.refused = 1'b1; // [R7]
                                next_r.lastRefused = 1'b1;
                                next_r.flashWe = 1'b0;
                                next_r.done = 1'b1;
                            end else if ((psda_op_t'(coreOp) == OP_TABLE_WRITE_UPPER)
                                         && coreByteMode && coreEa[`PSDA_EA_BYTE_BIT]) begin
                                // The phantom byte has no storage; nothing is written.
                                next_r.flashWe = 1'b0;
                                next_r.done = 1'b1;
                            end else begin
                                next_r.flashReq = 1'b1;
                                next_r.state = ST_TABLE_WRITE;
                            end
                        end
                        default: begin
                            next_r.refused = 1'b1;
                            next_r.lastRefused = 1'b1;
                            next_r.done = 1'b1;
                        end
                    endcase
                    if (next_r.done && !next_r.refused) begin
                        next_r.lastRefused = 1'b0;
                    end
                end
            end
            ST_TABLE_FETCH: begin
                if (flashAck) begin
                    next_r.flashReq = 1'b0;
                    next_r.done = 1'b1;
                    next_r.lastRefused = 1'b0;
                    next_r.state = ST_IDLE;
                    if (r.op == OP_TABLE_READ_LOW) begin
                        if (!r.byteMode) begin
                            next_r.rdData = flashRdData[15:0]; // [R1]
                        end else if (r.byteSel) begin
                            next_r.rdData = {8'h00, flashRdData[15:8]}; // [R2]
                        end else begin
                            next_r.rdData = {8'h00, flashRdData[7:0]}; // [R2]
                        end
                    end else if (!r.byteMode) begin
                        next_r.rdData = {8'h00, flashRdData[23:16]}; // [R3]
                    end else if (r.byteSel) begin
                        next_r.rdData = 16'h0000; // [R4]
                    end else begin
                        next_r.rdData = {8'h00, flashRdData[23:16]}; // [R4]
                    end
                end
            end
            ST_TABLE_WRITE: begin
                // Each latched word counts toward the current row of the array.
                if (flashAck) begin
                    next_r.flashReq = 1'b0;
                    next_r.flashWe = 1'b0;
                    next_r.done = 1'b1;
                    next_r.lastRefused = 1'b0;
                    next_r.state = ST_IDLE;
                    next_r.eraseBlock = r.flashAddr[23:`PSDA_ERASE_ADDR_LSB]; // [R18]
                    if (r.rowCount == `PSDA_ROW_WORDS - 7'h01) begin
                        next_r.rowCount = 7'h00; // [R18]
                    end else begin
                        next_r.rowCount = r.rowCount + 7'h01; // [R18]
                    end
                end
            end
            ST_WIN_FETCH1: begin
                // First of the two program fetches; the request stays up.
                if (flashAck) begin
                    next_r.rdData = flashRdData[15:0]; // [R12]
                    next_r.state = ST_WIN_FETCH2; // [R13]
                end
            end
            ST_WIN_FETCH2: begin
                if (flashAck) begin
                    next_r.flashReq = 1'b0; // [R13]
                    next_r.stall = r.extra;
                    if (r.extra == 2'h0) begin
                        next_r.done = 1'b1;
                        next_r.lastRefused = 1'b0;
                        next_r.state = ST_IDLE;
                    end else begin
                        next_r.state = ST_WIN_STALL;
                    end
                end
            end
            ST_WIN_STALL: begin
                // Holds the answer for the charged extra instruction cycles.
                next_r.stall = r.stall - 2'h1; // [R14] [R15]
                if (r.stall == 2'h1) begin
                    next_r.done = 1'b1;
                    next_r.lastRefused = 1'b0;
                    next_r.state = ST_IDLE;
                end
            end
            default: begin
                next_r.state = ST_IDLE;
                next_r.flashReq = 1'b0;
            end
        endcase
    end

    // =================================================================
    // State register
    // =================================================================

    // Registers the whole state; synchronous reset.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.tablePage <= `PSDA_RST_PAGE;
            r.visPage <= `PSDA_RST_PAGE;
            r.windowEnable <= `PSDA_RST_WIN_EN;
        end else begin
            r <= next_r;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================

    // A new access, window or table, is taken only in idle. [R16]
    assign coreReady = (r.state == ST_IDLE);
    assign coreDone = r.done;
    assign coreRdData = r.rdData;
    assign coreRefused = r.refused;
    assign coreRedirected = r.redirected;
    assign coreExtra = r.extra;
    assign flashReq = r.flashReq;
    assign flashWe = r.flashWe;
    assign flashMask = r.flashMask;
    assign flashAddr = r.flashAddr;
    assign flashWrData = r.flashWrData;
    assign avs_readdata = r.busRdData;
    assign avs_waitrequest = busReq & ~r.busAck;

endmodule

// ### psda_bridge_test.sv
// Self-checking bench for the program space data access bridge.
// Assumes the flash model and the bound checker are compiled alongside.
module psda_bridge_test
    import psda_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, coreReq, coreByteMode;
    logic coreIsMove, coreInRepeat, coreRepeatEdge, coreReady, coreDone, coreRefused;
    logic coreRedirected, flashReq, flashWe, flashAck;
    logic [1:0] coreExtra, lat;
    logic [2:0] coreOp, flashMask;
    logic [3:0] avs_byteenable;
    logic [4:0] avs_address;
    logic [15:0] coreEa, coreWrData, coreRdData;
    logic [23:0] flashAddr, flashWrData, flashRdData, w;
    logic [31:0] avs_writedata, avs_readdata, seed, r, q;
    logic [7:0] tp, vp;
    int fails, checks_done, i;
    psda_bridge dut_u (.*);
    psda_flash_model flash_u (.*);
    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [23:0] pw(input logic [23:0] a);
        return {a[2] ? 8'hFF : 8'h00, a[15:0] ^ a[23:8]};
    endfunction
    function automatic logic [15:0] exp_tbl(input logic hi, bm, input logic [15:0] ea);
        logic [23:0] x;
        x = pw({tp, ea[15:1], 1'b0});
        if (hi) return (bm && ea[0]) ? 16'h0000 : {8'h00, x[23:16]};
        if (bm) return {8'h00, ea[0] ? x[15:8] : x[7:0]};
        return x[15:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        {avs_read, avs_write} <= {!wr, wr};
        do @(negedge clk_sys); while (avs_waitrequest !== 1'b0);
        @(posedge clk_sys);
        q = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
    endtask
    task automatic op(input logic [2:0] o, input logic bm, input logic [15:0] ea,
                      input logic [2:0] f);
        @(posedge clk_sys);
        coreOp <= o;
        coreByteMode <= bm;
        coreEa <= ea;
        coreWrData <= 16'(rnd());
        {coreIsMove, coreInRepeat, coreRepeatEdge} <= f;
        lat <= 2'(rnd());
        coreReq <= 1'b1;
        @(posedge clk_sys);
        coreReq <= 1'b0;
        do @(negedge clk_sys); while (coreDone !== 1'b1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Free-running 25 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        {sys_rst, seed, coreIsMove, coreInRepeat, coreRepeatEdge} = {1'b1, 32'h00005DB5, 3'h0};
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {39'h0, 4'hF};
        {coreReq, coreOp, coreByteMode, coreEa, coreWrData, lat} = 39'h0;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk(q, 32'h0);
        end
        $display("register reset test ended");
        tp = 8'(rnd()) & 8'h7F;
        bus(1'b1, 5'h00, {24'h0, tp});
        for (i = 0; i < 24; i++) begin
            r = rnd();
            op(3'(3'h2 + r[16]), r[17], r[15:0], 3'h0);
            chk(coreRdData, exp_tbl(r[16], r[17], r[15:0]));
            chk(coreRefused, 1'b0);
        end
        for (i = 4; i < 6; i++) begin
            op(3'(i), 1'b0, 16'(rnd()), 3'h0);
            chk(coreRefused, 1'b0);
        end
        bus(1'b0, 5'h10, 32'h0);
        chk(q[6:0], 7'h02);
        $display("user table test ended");
        tp = 8'h80;
        bus(1'b1, 5'h00, 32'h80);
        op(3'h2, 1'b0, 16'h07FE, 3'h0);
        chk(coreRdData, exp_tbl(1'b0, 1'b0, 16'h07FE));
        op(3'h2, 1'b0, 16'h0800, 3'h0);
        chk(coreRefused, 1'b1);
        op(3'h4, 1'b0, 16'h0010, 3'h0);
        chk(coreRefused, 1'b1);
        $display("configuration test ended");
        vp = 8'(rnd());
        bus(1'b1, 5'h04, {24'h0, vp});
        bus(1'b1, 5'h08, 32'h4);
        for (i = 0; i < 16; i++) begin
            r = rnd();
            op(3'h0, 1'b0, {1'b1, r[14:0]}, r[18:16]);
            w = pw({1'b0, vp, r[14:1], 1'b0});
            chk(coreRedirected, 1'b1);
            chk(coreRdData, w[15:0]);
            chk(coreExtra, r[17] ? (r[16] ? 2'h2 : 2'h0) : (r[18] ? 2'h1 : 2'h2));
        end
        op(3'h0, 1'b0, 16'h7FFE, 3'h0);
        chk(coreRedirected, 1'b0);
        op(3'h1, 1'b0, 16'h8000, 3'h0);
        chk(coreRefused, 1'b1);
        bus(1'b1, 5'h08, 32'h0);
        op(3'h0, 1'b0, 16'h9234, 3'h0);
        chk(coreRedirected, 1'b0);
        $display("window test ended");
        report_and_stop();
    end
endmodule

// ### psda_flash_model.sv
// Behavioural program flash array answering each request after lat cycles.
// Assumes the bridge holds flashReq until it sees flashAck.
module psda_flash_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic flashReq,
    input wire logic [23:0] flashAddr,
    input wire logic [1:0] lat,
    output logic flashAck,
    output logic [23:0] flashRdData
);
    logic [1:0] cnt;
    // Stored word; upper byte is all ones or all zeros for window data.
    function automatic logic [23:0] pw(input logic [23:0] a);
        return {a[2] ? 8'hFF : 8'h00, a[15:0] ^ a[23:8]};
    endfunction
    // Answers after the delay; read data toggles when not valid.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flashAck <= 1'b0;
            cnt <= 2'h0;
            flashRdData <= 24'h000000;
        end else if (flashReq && !flashAck && cnt == lat) begin
            flashAck <= 1'b1;
            cnt <= 2'h0;
            flashRdData <= pw(flashAddr);
        end else begin
            flashAck <= 1'b0;
            cnt <= (flashReq && !flashAck) ? cnt + 2'h1 : 2'h0;
            flashRdData <= ~flashRdData;
        end
    end
endmodule

// ### psda_params.svh
// Constants for the program space data access bridge: register offsets,
// field positions, reset values and geometry of the program array.
// Assumes it is included by bare name from the package and the bridge.
`ifndef PSDA_PARAMS_SVH
`define PSDA_PARAMS_SVH

// =====================================================================
// Register byte offsets on the Avalon-MM slave
// =====================================================================
`define PSDA_REG_TABLE_PAGE 5'h00
`define PSDA_REG_VIS_PAGE 5'h04
`define PSDA_REG_CORE_CTRL 5'h08
`define PSDA_REG_STATUS 5'h0C
`define PSDA_REG_ROW_STAT 5'h10

// =====================================================================
// Field positions
// =====================================================================
`define PSDA_WIN_EN_BIT 2
`define PSDA_CFG_SPACE_BIT 7
`define PSDA_EA_WINDOW_BIT 15
`define PSDA_EA_BYTE_BIT 0
`define PSDA_ST_BUSY_BIT 0
`define PSDA_ST_REFUSED_BIT 1
`define PSDA_ST_SUSPEND_BIT 2
`define PSDA_RS_COUNT_LSB 0
`define PSDA_RS_BLOCK_LSB 8

// =====================================================================
// Reset values
// =====================================================================
`define PSDA_RST_PAGE 8'h00
`define PSDA_RST_WIN_EN 1'b0

// =====================================================================
// Program array geometry and window cycle penalties
// =====================================================================
`define PSDA_ROW_WORDS 7'h40
`define PSDA_ROW_BYTES 192
`define PSDA_ERASE_WORDS 512
`define PSDA_ERASE_BYTES 1536
`define PSDA_ERASE_ADDR_LSB 10
`define PSDA_PC_STEP 2
`define PSDA_PEN_MOVE 2'h1
`define PSDA_PEN_OTHER 2'h2
`define PSDA_PEN_REP_EDGE 2'h2
`define PSDA_PEN_REP_MID 2'h0

// =====================================================================
// Byte lane masks for flash writes
// =====================================================================
`define PSDA_MASK_LOW_WORD 3'h3
`define PSDA_MASK_BYTE0 3'h1
`define PSDA_MASK_BYTE1 3'h2
`define PSDA_MASK_HIGH 3'h4

`endif

// ### psda_pkg.sv
// Types shared by the program space data access bridge.
// Assumes psda_params.svh is on the include path.
`include "psda_params.svh"

package psda_pkg;

    // Operation requested by the core for one access.
    typedef enum logic [2:0] {
        OP_DATA_READ = 3'h0,
        OP_DATA_WRITE = 3'h1,
        OP_TABLE_READ_LOW = 3'h2,
        OP_TABLE_READ_UPPER = 3'h3,
        OP_TABLE_WRITE_LOW = 3'h4,
        OP_TABLE_WRITE_UPPER = 3'h5
    } psda_op_t;

    // Sequencer states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_TABLE_FETCH = 6'h02,
        ST_TABLE_WRITE = 6'h04,
        ST_WIN_FETCH1 = 6'h08,
        ST_WIN_FETCH2 = 6'h10,
        ST_WIN_STALL = 6'h20
    } psda_state_t;

    // Whole state of the bridge.
    typedef struct packed {
        psda_state_t state;
        logic [7:0] tablePage;
        logic [7:0] visPage;
        logic windowEnable;
        logic busAck;
        logic [31:0] busRdData;
        psda_op_t op;
        logic byteMode;
        logic byteSel;
        logic [1:0] stall;
        logic [15:0] rdData;
        logic done;
        logic refused;
        logic redirected;
        logic [1:0] extra;
        logic lastRefused;
        logic flashReq;
        logic flashWe;
        logic [2:0] flashMask;
        logic [23:0] flashAddr;
        logic [23:0] flashWrData;
        logic [6:0] rowCount;
        logic [13:0] eraseBlock;
    } psda_regs_t;

endpackage

// ### psda_properties.sv
// Port-level assertions for the program space data access bridge.
// Assumes the core holds op, address and flags steady until coreDone.
module psda_checker
    import psda_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic coreReq,
    input wire logic coreReady,
    input wire logic coreDone,
    input wire logic [2:0] coreOp,
    input wire logic [15:0] coreEa,
    input wire logic coreIsMove,
    input wire logic coreInRepeat,
    input wire logic coreRepeatEdge,
    input wire logic [15:0] coreRdData,
    input wire logic coreRefused,
    input wire logic coreRedirected,
    input wire logic [1:0] coreExtra,
    input wire logic flashReq,
    input wire logic [23:0] flashAddr,
    input wire logic flashAck
);
    // =========================================================
    // Helper logic
    // =========================================================
    logic [1:0] acks;
    wire winRd = coreDone && coreRedirected && !coreRefused && coreOp == 3'h0;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Counts flash answers since the last accepted core request.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (coreReq && coreReady)) begin
            acks <= 2'h0;
        end else if (flashAck && acks != 2'h3) begin
            acks <= acks + 2'h1;
        end
    end
    // =========================================================
    // Properties
    // =========================================================
    property p_lsb; flashReq |-> !flashAddr[0]; endproperty
    a_lsb: assert property (p_lsb) else $error("odd program address");
    property p_tbl_addr; flashReq && coreOp >= 3'h2 |-> flashAddr[15:1] == coreEa[15:1];
    endproperty
    a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
    property p_win_addr;
        flashReq && coreOp == 3'h0 |-> !flashAddr[23] && flashAddr[14:1] == coreEa[14:1];
    endproperty
    a_win_addr: assert property (p_win_addr) else $error("window address wrong");
    property p_two_fetch; winRd |-> acks == 2'h2; endproperty
    a_two_fetch: assert property (p_two_fetch) else $error("window fetch count");
    property p_refuse; coreDone && coreRefused |-> acks == 2'h0 && coreRdData == 16'h0000;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused access touched flash");
    property p_phantom; coreDone && coreOp == 3'h3 |-> coreRdData[15:8] == 8'h00; endproperty
    a_phantom: assert property (p_phantom) else $error("phantom byte not zero");
    property p_pen_out; winRd && !coreInRepeat |-> coreExtra == (coreIsMove ? 2'h1 : 2'h2);
    endproperty
    a_pen_out: assert property (p_pen_out) else $error("penalty outside repeat");
    property p_pen_rep; winRd && coreInRepeat |-> coreExtra == (coreRepeatEdge ? 2'h2 : 2'h0);
    endproperty
    a_pen_rep: assert property (p_pen_rep) else $error("penalty inside repeat");
    property p_suspend; $rose(flashReq) && coreOp >= 3'h2 |-> !coreReady [*2]; endproperty
    a_suspend: assert property (p_suspend) else $error("ready during table op");
    c_win: cover property (winRd);
    c_ref: cover property (coreDone && coreRefused);
    c_hi: cover property (coreDone && coreOp == 3'h3);
endmodule

bind psda_bridge psda_checker chk_u (.*);
